// file: dv/user_stack_exec_sva.sv
`timescale 1ns/1ps
`include "user_stack_cfg.svh"

module user_stack_exec_chk #(
  parameter int DATA_W = 8
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [DATA_W-1:0] dst_operand,
  input wire logic [DATA_W-1:0] src_operand,
  input wire logic [DATA_W-1:0] rf_rd_data,
  input wire logic [`FLAGS_W-1:0] flags_in,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal,
  input wire logic [DATA_W-1:0] rf_rd_addr,
  input wire logic rf_wr_en,
  input wire logic [DATA_W-1:0] rf_wr_addr,
  input wire logic [DATA_W-1:0] rf_wr_data,
  input wire logic flags_wr_en,
  input wire logic [`FLAGS_W-1:0] flags_wr_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_take(logic [7:0] o);
    start && !busy && opcode == o;
  endsequence
  // both push opcodes differ only in bit 0
  sequence s_push;
    start && !busy && opcode[7:1] == 7'h41;
  endsequence
  sequence s_bad;
    start && !busy && !(opcode inside {8'h82, 8'h83, 8'hCF});
  endsequence

  property p_dec_len;
    s_take(8'h82) |=> busy[*7] ##1 (done && !busy);
  endproperty
  property p_inc_len;
    s_take(8'h83) |=> busy[*7] ##1 (done && !busy);
  endproperty
  property p_dec_sp;
    s_take(8'h82) |-> ##3 rf_wr_en && rf_wr_addr == $past(dst_operand, 3)
      && rf_wr_data == $past(rf_rd_data, 2) - 8'h01;
  endproperty
  property p_inc_sp;
    s_take(8'h83) |-> ##3 rf_wr_en && rf_wr_addr == $past(dst_operand, 3)
      && rf_wr_data == $past(rf_rd_data, 2) + 8'h01;
  endproperty
  property p_data;
    s_push |-> ##4 rf_wr_en && rf_wr_addr == $past(rf_wr_data, 1)
      && rf_wr_data == $past(rf_rd_data, 2);
  endproperty
  property p_no_flags;
    s_push |=> !flags_wr_en[*8];
  endproperty
  property p_clr_data;
    s_take(8'hCF) |-> ##2 flags_wr_en && flags_wr_data == ($past(flags_in, 1) & 8'h7F);
  endproperty
  property p_clr_len;
    s_take(8'hCF) |=> busy[*3] ##1 (done && !busy && !flags_wr_en);
  endproperty
  // an unknown opcode only pulses illegal and never starts a write
  property p_illegal;
    s_bad |=> illegal && !busy && !rf_wr_en && !flags_wr_en;
  endproperty

  a_dec_len: assert property (p_dec_len) else $error("dec push timing");
  a_inc_len: assert property (p_inc_len) else $error("inc push timing");
  a_dec_sp: assert property (p_dec_sp) else $error("dec pointer");
  a_inc_sp: assert property (p_inc_sp) else $error("inc pointer");
  a_data: assert property (p_data) else $error("push data write");
  a_no_flags: assert property (p_no_flags) else $error("push wrote flags");
  a_clr_data: assert property (p_clr_data) else $error("carry clear value");
  a_clr_len: assert property (p_clr_len) else $error("carry clear timing");
  a_illegal: assert property (p_illegal) else $error("unknown opcode");
endmodule // user_stack_exec_chk

bind user_stack_exec user_stack_exec_chk #(.DATA_W(DATA_W)) i_user_stack_exec_chk
(
  .clk(clk),
  .arst_n(arst_n),
  .start(start),
  .opcode(opcode),
  .dst_operand(dst_operand),
  .src_operand(src_operand),
  .rf_rd_data(rf_rd_data),
  .flags_in(flags_in),
  .busy(busy),
  .done(done),
  .illegal(illegal),
  .rf_rd_addr(rf_rd_addr),
  .rf_wr_en(rf_wr_en),
  .rf_wr_addr(rf_wr_addr),
  .rf_wr_data(rf_wr_data),
  .flags_wr_en(flags_wr_en),
  .flags_wr_data(flags_wr_data)
);

// file: dv/user_stack_exec_test.sv
`timescale 1ns/1ps
`include "user_stack_cfg.svh"

module user_stack_exec_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00, dst_operand = 8'h00, src_operand = 8'h00, fl = 8'h00, fm;
  logic busy, done, illegal, rf_wr_en, flags_wr_en;
  logic [7:0] rf_rd_addr, rf_wr_addr, rf_wr_data, flags_wr_data;
  logic [7:0] rf [256];
  logic [7:0] rm [256];
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'h224a;
  // holds start high while busy, which the block must ignore
  logic jam = 1'b0;

  always #20 clk = ~clk;

  user_stack_exec i_user_stack_exec (.clk(clk), .arst_n(arst_n), .start(start),
    .opcode(opcode), .dst_operand(dst_operand), .src_operand(src_operand),
    .rf_rd_data(rf[rf_rd_addr]), .flags_in(fl), .busy(busy), .done(done),
    .illegal(illegal), .rf_rd_addr(rf_rd_addr), .rf_wr_en(rf_wr_en),
    .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data), .flags_wr_en(flags_wr_en),
    .flags_wr_data(flags_wr_data));

  // ----------------------------------------
  // register file and flags around the block
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rf_wr_en)
      rf[rf_wr_addr] <= rf_wr_data;
    if (flags_wr_en)
      fl <= flags_wr_data;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_idle();
    chk(busy, 1'b0);
    chk(done, 1'b0);
    chk(illegal, 1'b0);
    chk(rf_wr_en, 1'b0);
    chk(flags_wr_en, 1'b0);
  endtask

  task automatic setr(input logic [7:0] a, input logic [7:0] v);
    rf[a] = v;
    rm[a] = v;
  endtask

  // model reads src before moving the pointer, so a self-push stores the old pointer
  task automatic instr(input logic [7:0] op, input logic [7:0] p, input logic [7:0] s);
    logic [7:0] sp;
    logic [7:0] v;
    int cyc;
    int n;
    sp = rm[p];
    v = rm[s];
    cyc = 1;
    if (op == 8'h82 || op == 8'h83)
    begin
      sp = (op == 8'h82) ? sp - 8'h01 : sp + 8'h01;
      rm[p] = sp;
      rm[sp] = v;
      cyc = 8;
    end
    if (op == 8'hCF)
    begin
      fm[`CARRY_BIT] = 1'b0;
      cyc = 4;
    end
    start = 1'b1;
    opcode = op;
    dst_operand = p;
    src_operand = s;
    n = 0;
    // start is left alone at the edge that ends the instruction, so that a
    // following call raises it without a second assignment in that step
    do
    begin
      @(negedge clk);
      n++;
      if (!(done === 1'b1 || illegal === 1'b1))
        start = jam;
    end while (!(done === 1'b1 || illegal === 1'b1) && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      end_sim();
    end
    else
    begin
      chk(n, cyc);
      chk(illegal, cyc == 1);
      chk(fl, fm);
      for (int i = 0; i < 256; i++)
        chk(rf[i], rm[i]);
    end
  endtask

  initial
  begin
    logic [31:0] r;
    for (int i = 0; i < 256; i++)
      setr(i[7:0], 8'($random(seed)));
    fm = fl;
    repeat (4) @(negedge clk);
    chk_idle();
    arst_n = 1'b1;
    @(negedge clk);
    chk_idle();
    setr(8'h10, 8'h00);
    instr(8'h82, 8'h10, 8'h20);
    setr(8'h10, 8'hFF);
    instr(8'h83, 8'h10, 8'h10);
    fl = 8'hFF;
    fm = fl;
    instr(8'hCF, 8'h00, 8'h00);
    // a push cut by reset before its first write must leave the file untouched
    start = 1'b1;
    opcode = 8'h82;
    dst_operand = 8'h10;
    src_operand = 8'h20;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    chk_idle();
    arst_n = 1'b1;
    @(negedge clk);
    chk_idle();
    for (int i = 0; i < 256; i++)
      chk(rf[i], rm[i]);
    repeat (300)
    begin
      r = $random(seed);
      fl = 8'($random(seed));
      fm = fl;
      jam = r[4];
      instr(r[1:0] == 2'h0 ? 8'h82 : r[1:0] == 2'h1 ? 8'h83 : r[1:0] == 2'h2 ? 8'hCF : r[15:8],
        r[23:16], r[31:24]);
    end
    end_sim();
  end
endmodule // user_stack_exec_test

// file: verilog/decode_if.sv
`timescale 1ns/1ps
`include "user_stack_cfg.svh"

interface decode_if;
  import user_stack_pkg::*;
  logic [7:0] opcode;
  op_t op;
  logic [`CYCLE_CNT_W-1:0] cycles;
  logic [1:0] bytes;

  modport decoder
  (
    input opcode,
    output op,
    output cycles,
    output bytes
  );

  modport core
  (
    output opcode,
    input op,
    input cycles,
    input bytes
  );
endinterface

// file: verilog/opcode_decoder.sv
`timescale 1ns/1ps
`include "user_stack_cfg.svh"

module opcode_decoder
  import user_stack_pkg::*;
(
  decode_if.decoder dec
);

  always_comb
  begin
    dec.op = op_none;
    dec.cycles = '0;
    dec.bytes = '0;
    case (dec.opcode)
      `OPC_PUSH_USER_STACK_DEC:
      begin
        dec.op = op_push_dec; // see [RULE1]
        dec.cycles = `PUSH_CYCLES;
        dec.bytes = `PUSH_BYTES;
      end
      `OPC_PUSH_USER_STACK_INC:
      begin
        dec.op = op_push_inc; // see [RULE4]
        dec.cycles = `PUSH_CYCLES;
        dec.bytes = `PUSH_BYTES;
      end
      `OPC_CLEAR_CARRY:
      begin
        dec.op = op_clear_carry; // see [RULE7]
        dec.cycles = `CLEAR_CARRY_CYCLES;
        dec.bytes = `CLEAR_CARRY_BYTES;
      end
      default:
      begin
        dec.op = op_none;
      end
    endcase
  end

endmodule // opcode_decoder

// file: verilog/user_stack_cfg.svh
`ifndef USER_STACK_CFG_SVH
`define USER_STACK_CFG_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OPC_PUSH_USER_STACK_DEC 8'h82
`define OPC_PUSH_USER_STACK_INC 8'h83
`define OPC_CLEAR_CARRY 8'hCF

// ----------------------------------------
// instruction lengths and cycle counts
// ----------------------------------------
`define PUSH_BYTES 2'h3
`define PUSH_CYCLES 4'h8
`define CLEAR_CARRY_BYTES 2'h1
`define CLEAR_CARRY_CYCLES 4'h4
`define CYCLE_CNT_W 4

// ----------------------------------------
// flags register layout
// ----------------------------------------
`define CARRY_BIT 7
`define FLAGS_W 8

`endif

// file: verilog/user_stack_exec.sv
`timescale 1ns/1ps
`include "user_stack_cfg.svh"

// Contract
// [RULE1] opcode 82 hex is the decrementing user-stack push, three bytes, eight cycles, indirect dst and register src.
// [RULE2] the decrementing push first lowers the user stack pointer by one, then writes src to the register it points at.
// [RULE3] neither user-stack push touches any bit of the flags register.
// [RULE4] opcode 83 hex is the incrementing user-stack push, three bytes, eight cycles, indirect dst and register src.
// [RULE5] the incrementing push first raises the user stack pointer by one, then writes src to the register it points at.
// [RULE6] the user stack pointer is an ordinary register whose content is the register file address of the write.
// [RULE7] opcode CF hex is one byte, four cycles, clears carry regardless of its value and leaves other flags alone.
// [RULE8] the pointer step is modulo 256 and wraps between 00 and FF hex without raising a flag.

module user_stack_exec
  import user_stack_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [DATA_W-1:0] dst_operand,
  input wire logic [DATA_W-1:0] src_operand,
  input wire logic [DATA_W-1:0] rf_rd_data,
  input wire logic [`FLAGS_W-1:0] flags_in,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [DATA_W-1:0] rf_rd_addr,
  output logic rf_wr_en,
  output logic [DATA_W-1:0] rf_wr_addr,
  output logic [DATA_W-1:0] rf_wr_data,
  output logic flags_wr_en,
  output logic [`FLAGS_W-1:0] flags_wr_data
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  // the pointer wrap and the register file address are defined for bytes only
  if (DATA_W != 8)
  begin : g_width_check
    $error("user_stack_exec supports DATA_W of 8 only");
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  decode_if dec_bus ();

  assign dec_bus.opcode = opcode;

  opcode_decoder u_dec
  (
    .dec(dec_bus)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  state_t state_q, state_d;
  op_t op_q, op_d;
  logic [`CYCLE_CNT_W-1:0] cnt_q, cnt_d;
  logic [`CYCLE_CNT_W-1:0] last_q, last_d;
  logic [DATA_W-1:0] ptr_reg_q, ptr_reg_d;
  logic [DATA_W-1:0] src_reg_q, src_reg_d;
  logic [DATA_W-1:0] new_sp_q, new_sp_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic illegal_q, illegal_d;
  logic [DATA_W-1:0] rd_addr_q, rd_addr_d;
  logic wr_en_q, wr_en_d;
  logic [DATA_W-1:0] wr_addr_q, wr_addr_d;
  logic [DATA_W-1:0] wr_data_q, wr_data_d;
  logic fl_en_q, fl_en_d;
  logic [`FLAGS_W-1:0] fl_data_q, fl_data_d;
  logic [DATA_W-1:0] sp_step;

  // plain modular step, no carry out is kept so nothing reaches the flags
  always_comb
  begin
    if (op_q == op_push_dec)
    begin
      sp_step = rf_rd_data - DATA_W'(1); // see [RULE2] see [RULE8]
    end
    else
    begin
      sp_step = rf_rd_data + DATA_W'(1); // see [RULE5] see [RULE8]
    end
  end

  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    cnt_d = cnt_q;
    last_d = last_q;
    ptr_reg_d = ptr_reg_q;
    src_reg_d = src_reg_q;
    new_sp_d = new_sp_q;
    busy_d = busy_q;
    done_d = 1'b0;
    illegal_d = 1'b0;
    rd_addr_d = rd_addr_q;
    wr_en_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    fl_en_d = 1'b0;
    fl_data_d = fl_data_q;
    if (state_q != st_idle)
    begin
      cnt_d = cnt_q + `CYCLE_CNT_W'(1);
    end
    case (state_q)
      st_idle:
      begin
        if (start)
        begin
          if (dec_bus.op == op_none)
          begin
            illegal_d = 1'b1;
          end
          else
          begin
            op_d = dec_bus.op;
            last_d = dec_bus.cycles - `CYCLE_CNT_W'(1);
            cnt_d = `CYCLE_CNT_W'(1);
            busy_d = 1'b1;
            ptr_reg_d = dst_operand;
            rd_addr_d = dst_operand; // see [RULE6]
            if (dec_bus.op == op_clear_carry)
            begin
              state_d = st_clear_carry;
            end
            else
            begin
              state_d = st_read_sp;
            end
          end
        end
      end
      st_read_sp:
      begin
        // src is read before the pointer is written, so a src equal to the
        // pointer register pushes the old pointer value
        new_sp_d = sp_step;
        rd_addr_d = src_operand;
        state_d = st_read_src;
      end
      st_read_src:
      begin
        src_reg_d = rf_rd_data;
        wr_en_d = 1'b1;
        wr_addr_d = ptr_reg_q;
        wr_data_d = new_sp_q; // see [RULE2] see [RULE5]
        state_d = st_write_data;
      end
      st_write_data:
      begin
        wr_en_d = 1'b1;
        wr_addr_d = new_sp_q; // see [RULE6]
        wr_data_d = src_reg_q; // see [RULE2] see [RULE5]
        state_d = st_wait; // see [RULE3]
      end
      st_clear_carry:
      begin
        fl_en_d = 1'b1;
        fl_data_d = flags_in;
        fl_data_d[`CARRY_BIT] = 1'b0; // see [RULE7]
        state_d = st_wait;
      end
      st_wait:
      begin
        if (cnt_q == last_q)
        begin
          done_d = 1'b1; // see [RULE1] see [RULE4] see [RULE7]
          busy_d = 1'b0;
          state_d = st_idle;
        end
      end
      default:
      begin
        state_d = st_idle;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= st_idle;
      op_q <= op_none;
      cnt_q <= '0;
      last_q <= '0;
      ptr_reg_q <= '0;
      src_reg_q <= '0;
      new_sp_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      rd_addr_q <= '0;
      wr_en_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      fl_en_q <= 1'b0;
      fl_data_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      ptr_reg_q <= ptr_reg_d;
      src_reg_q <= src_reg_d;
      new_sp_q <= new_sp_d;
      busy_q <= busy_d;
      done_q <= done_d;
      illegal_q <= illegal_d;
      rd_addr_q <= rd_addr_d;
      wr_en_q <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      fl_en_q <= fl_en_d;
      fl_data_q <= fl_data_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign busy = busy_q;
  assign done = done_q;
  assign illegal = illegal_q;
  assign rf_rd_addr = rd_addr_q;
  assign rf_wr_en = wr_en_q;
  assign rf_wr_addr = wr_addr_q;
  assign rf_wr_data = wr_data_q;
  assign flags_wr_en = fl_en_q;
  assign flags_wr_data = fl_data_q;

endmodule // user_stack_exec

// file: verilog/user_stack_pkg.sv
package user_stack_pkg;

  typedef enum logic [1:0]
  {
    op_none,
    op_push_dec,
    op_push_inc,
    op_clear_carry
  } op_t;

  typedef enum logic [2:0]
  {
    st_idle,
    st_read_sp,
    st_read_src,
    st_write_data,
    st_clear_carry,
    st_wait
  } state_t;

endpackage
